//--- core/ucsf_break_det.sv
`timescale 1ns/1ps
module ucsf_break_det (
  input  wire logic sys_clk,   // Core clock
  input  wire logic nrst,      // Async reset, active low
  input  wire logic enable,    // Receive enable
  input  wire logic bit_stb,   // One received bit sampled
  input  wire logic bit_val,   // Value of that bit
  output logic      brk_pulse, // Break seen, one cycle
  output logic      idle_hold  // Receiver held idle after a break
);

  typedef enum logic {
    BRK_HUNT = 1'b0,
    BRK_HOLD = 1'b1
  } ucsf_brk_e;

  typedef struct packed {
    ucsf_brk_e  state;
    logic [3:0] cnt;
    logic       pulse;
  } ucsf_brk_s;

  ucsf_brk_s st_q;
  ucsf_brk_s st_d;

  always_comb begin
    st_d       = st_q;
    st_d.pulse = 1'b0;
    if (!enable) begin
      st_d.state = BRK_HUNT;
      st_d.cnt   = 4'h0;
    end else begin
      case (st_q.state)
        BRK_HUNT: begin
          if (bit_stb && !bit_val) begin
            if (st_q.cnt == ucsf_pkg::BREAK_BITS - 4'h1) begin
              st_d.pulse = 1'b1; // R15
              st_d.state = BRK_HOLD;
              st_d.cnt   = 4'h0;
            end else begin
              st_d.cnt = st_q.cnt + 4'h1;
            end
          end else if (bit_stb) begin
            st_d.cnt = 4'h0;
          end
        end
        BRK_HOLD: begin
          // A high sample, a stop bit, ends the idle spell here; clearing enable also ends it
          if (bit_stb && bit_val) begin
            st_d.state = BRK_HUNT; // R19
          end
        end
        default: st_d.state = BRK_HUNT;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{state: BRK_HUNT, cnt: 4'h0, pulse: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign brk_pulse = st_q.pulse;
  assign idle_hold = (st_q.state == BRK_HOLD);

endmodule : ucsf_break_det

//--- core/ucsf_pkg.sv
package ucsf_pkg;

  // Register indices; the bus byte address is four times the index
  localparam logic [7:0]  IDX_CTRL      = 8'h98;
  localparam logic [7:0]  IDX_STAT      = 8'hba;
  localparam logic [7:0]  IDX_PWR       = 8'h87;
  localparam logic [7:0]  IDX_AUX       = 8'hc0;
  localparam logic [11:0] ADDR_CTRL     = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [11:0] ADDR_STAT     = {2'b00, IDX_STAT, 2'b00};
  localparam logic [11:0] ADDR_PWR      = {2'b00, IDX_PWR, 2'b00};
  localparam logic [11:0] ADDR_AUX      = {2'b00, IDX_AUX, 2'b00};

  // serial_control fields
  localparam int unsigned CTL_RX_DONE   = 0;
  localparam int unsigned CTL_TX_DONE   = 1;
  localparam int unsigned CTL_NINTH_RX  = 2;
  localparam int unsigned CTL_NINTH_TX  = 3;
  localparam int unsigned CTL_RX_EN     = 4;
  localparam int unsigned CTL_MP_FILT   = 5;
  localparam int unsigned CTL_MODE_LO   = 6;
  localparam int unsigned CTL_BIT7      = 7;
  // serial_status fields
  localparam int unsigned STS_IRQ_EN    = 0;
  localparam int unsigned STS_OVERRUN   = 1;
  localparam int unsigned STS_BREAK     = 2;
  localparam int unsigned STS_FRAME     = 3;
  localparam int unsigned STS_DBISEL    = 4;
  localparam int unsigned STS_SPLIT     = 5;
  localparam int unsigned STS_INTLO     = 6;
  localparam int unsigned STS_DBMOD     = 7;
  // power_control_reg and auxiliary fields
  localparam int unsigned PWR_FUNC_SEL  = 6;
  localparam int unsigned PWR_RATE_DBL  = 7;
  localparam int unsigned AUX_BRK_RST   = 0;

  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  STAT_RST      = 8'h00;
  localparam logic [7:0]  PWR_RST       = 8'h00;
  localparam logic [7:0]  AUX_RST       = 8'h00;

  localparam logic [3:0]  BREAK_BITS    = 4'hb;
  localparam logic [5:0]  DIV_SHIFT     = 6'h10;
  localparam logic [5:0]  DIV_NINE_SLOW = 6'h20;
  localparam logic [5:0]  DIV_NINE_FAST = 6'h10;
  localparam logic [5:0]  DIV_VARIABLE  = 6'h00;

  localparam logic [1:0]  RESP_OKAY     = 2'b00;
  localparam logic [1:0]  RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {
    MODE_SHIFT      = 2'b00,
    MODE_ASYNC8     = 2'b01,
    MODE_NINE_FIXED = 2'b10,
    MODE_NINE_VAR   = 2'b11
  } ucsf_mode_e;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_CTRL = 3'b001,
    SEL_STAT = 3'b010,
    SEL_PWR  = 3'b011,
    SEL_AUX  = 3'b100
  } ucsf_sel_e;

  function automatic ucsf_sel_e ucsf_decode(input logic [11:0] addr);
    ucsf_sel_e sel;
    if (addr == ADDR_CTRL) begin
      sel = SEL_CTRL;
    end else if (addr == ADDR_STAT) begin
      sel = SEL_STAT;
    end else if (addr == ADDR_PWR) begin
      sel = SEL_PWR;
    end else if (addr == ADDR_AUX) begin
      sel = SEL_AUX;
    end else begin
      sel = SEL_NONE;
    end
    return sel;
  endfunction : ucsf_decode

endpackage : ucsf_pkg

//--- core/ucsf_rate_sel.sv
`timescale 1ns/1ps
module ucsf_rate_sel (
  input  wire logic [1:0] mode,      // Mode select pair
  input  wire logic       rate_dbl,  // Doubles the fixed 9-bit rate
  output logic            nine_bit,  // Ninth data bit in the frame
  output logic            fixed,     // Rate is a fixed core clock fraction
  output logic [5:0]      div        // Core clock divisor, 0 when variable
);

  always_comb begin
    nine_bit = 1'b0;
    fixed    = 1'b0;
    div      = ucsf_pkg::DIV_VARIABLE;
    case (mode)
      ucsf_pkg::MODE_SHIFT: begin
        fixed = 1'b1;
        div   = ucsf_pkg::DIV_SHIFT;
      end
      ucsf_pkg::MODE_ASYNC8: fixed = 1'b0;
      ucsf_pkg::MODE_NINE_FIXED: begin
        nine_bit = 1'b1;
        fixed    = 1'b1;
        div      = rate_dbl ? ucsf_pkg::DIV_NINE_FAST : ucsf_pkg::DIV_NINE_SLOW;
      end
      default: begin
        nine_bit = 1'b1;
      end
    endcase
  end

endmodule : ucsf_rate_sel

//--- core/ucsf_top.sv
// What this block does
// R1: In 9-bit modes the ninth sent bit is control bit 3.
// R2: Frames are taken only while receive enable, control bit 4, is set.
// R3: 9-bit modes with filter set: no receive-done if ninth bit is 0.
// R4: Software keeps the filter bit 0 in modes 0 and 1.
// R5: Control bit 7 is upper mode bit, or framing flag if function select is 1.
// R6: Bit 7 framing flag sets on bad stop, clears only by software.
// R7: Software writes mode bits only while function select is 0.
// R8: Mode 00 shift, 01 8-bit variable, 10 9-bit /32 or /16, 11 9-bit variable.
// R9: After reset: shift-register mode at core clock over 16.
// R10: Status enable set: framing, break, overrun request the serial interrupt.
// R11: Status enable clear: those three flags request no interrupt.
// R12: Receive-done requests its interrupt whatever the status enable.
// R13: Break-reset enable set: a detected break requests a device reset.
// R14: Overrun sets when bit 8 arrives while receive-done is set.
// R15: Break flag sets after 11 consecutive low bits; software clears it.
// R16: Status framing flag sets on a missing stop bit; software clears it.
// R17: Split select 1: separate receive and transmit requests; 0: combined.
// R18: Function select for bit 7 is power control register bit 6.
// R19: After a break the receiver idles until a stop bit; framing is reported.
// R20: Flags clear on a written 0; a same-cycle hardware set wins.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module ucsf_top (
  input  wire logic        sys_clk,         // Core clock, 100 MHz
  input  wire logic        nrst,            // Async reset, active low
  input  wire logic [11:0] s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [11:0] s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  input  wire logic        rx_bit_stb,      // Receiver sampled one bit
  input  wire logic        rx_bit_val,      // Value of the sampled bit
  input  wire logic        rx_bit8_stb,     // Bit 8 of a new character arrived
  input  wire logic        rx_frame_stb,    // Receiver closed a frame
  input  wire logic        rx_ninth_in,     // Received ninth data bit
  input  wire logic        rx_stop_ok,      // Stop bit of that frame was high
  input  wire logic        tx_done_stb,     // Transmitter finished a character
  output logic [1:0]       uart_mode,       // Selected mode
  output logic             nine_bit_mode,   // Frames carry a ninth data bit
  output logic             fixed_rate,      // Rate is a fixed core clock fraction
  output logic [5:0]       rate_div,        // Core clock divisor, 0 when variable
  output logic             ninth_tx_bit,    // Ninth bit to transmit
  output logic             rx_enable,       // Receiver may take characters
  output logic             irq_rx_req,      // Receive or combined interrupt request
  output logic             irq_tx_req,      // Separate transmit interrupt request
  output logic             break_reset_req  // Device reset request, one cycle
);

  typedef struct packed {
    logic        aw_have;
    logic [11:0] aw_addr;
    logic        w_have;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [1:0]  rresp;
    logic [1:0]  mode;
    logic        mp_filt;
    logic        rx_en;
    logic        ninth_tx;
    logic        ninth_rx;
    logic        tx_done;
    logic        rx_done;
    logic        frame_err;
    logic        overrun;
    logic        brk;
    logic        irq_en;
    logic        dbisel;
    logic        split;
    logic        intlo;
    logic        dbmod;
    logic        func_sel;
    logic        rate_dbl;
    logic        brk_rst_en;
    logic        irq_rx;
    logic        irq_tx;
    logic        brk_rst;
    logic        fixed;
    logic [5:0]  div;
  } ucsf_state_s;

  ucsf_state_s st_q;
  ucsf_state_s st_d;

  logic       brk_pulse;
  logic       idle_hold;
  logic       nine_d;
  logic       fixed_d;
  logic [5:0] div_d;
  logic [7:0] ctrl_view;
  logic [7:0] stat_view;

  ucsf_break_det u_break (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .enable    (st_q.rx_en),
    .bit_stb   (rx_bit_stb),
    .bit_val   (rx_bit_val),
    .brk_pulse (brk_pulse),
    .idle_hold (idle_hold)
  );

  ucsf_rate_sel u_rate (
    .mode     (st_d.mode),
    .rate_dbl (st_d.rate_dbl),
    .nine_bit (nine_d),
    .fixed    (fixed_d),
    .div      (div_d)
  );

  // Bit 7 follows the function select on reads
  assign ctrl_view = {(st_q.func_sel ? st_q.frame_err : st_q.mode[1]), // R5
                      st_q.mode[0], st_q.mp_filt, st_q.rx_en, st_q.ninth_tx,
                      st_q.ninth_rx, st_q.tx_done, st_q.rx_done};
  assign stat_view = {st_q.dbmod, st_q.intlo, st_q.split, st_q.dbisel,
                      st_q.frame_err, st_q.brk, st_q.overrun, st_q.irq_en};

  always_comb begin
    ucsf_pkg::ucsf_sel_e wsel;
    ucsf_pkg::ucsf_sel_e rsel;
    logic                wr_go;
    logic                frame_acc;
    logic                filtered;
    logic                set_ri;
    logic                set_fe;
    logic                set_oe;
    logic                clr_ri;
    logic                clr_ti;
    logic                clr_fe;
    logic                clr_br;
    logic                clr_oe;
    logic                status_req;
    st_d       = st_q;
    wsel       = ucsf_pkg::ucsf_decode(st_q.aw_addr);
    rsel       = ucsf_pkg::ucsf_decode(s_axi_araddr);
    wr_go      = st_q.aw_have && st_q.w_have && !st_q.bvalid;
    clr_ri     = 1'b0;
    clr_ti     = 1'b0;
    clr_fe     = 1'b0;
    clr_br     = 1'b0;
    clr_oe     = 1'b0;
    status_req = 1'b0;

    // No frames while disabled or idling after a break
    frame_acc = rx_frame_stb && st_q.rx_en && !idle_hold; // R2
    filtered  = st_q.mode[1] && st_q.mp_filt && !rx_ninth_in; // R3
    set_ri    = frame_acc && !filtered;
    set_fe    = (frame_acc && !rx_stop_ok && (st_q.mode != ucsf_pkg::MODE_SHIFT))
                || brk_pulse; // R16 R6 R19
    set_oe    = rx_bit8_stb && st_q.rx_en && st_q.rx_done; // R14

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_have  = 1'b1;
      st_d.w_data  = s_axi_wdata[7:0];
      st_d.w_lane0 = s_axi_wstrb[0];
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wr_go) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = (wsel == ucsf_pkg::SEL_NONE) ? ucsf_pkg::RESP_SLVERR
                                                  : ucsf_pkg::RESP_OKAY;
      if (st_q.w_lane0) begin
        if (wsel == ucsf_pkg::SEL_CTRL) begin
          if (st_q.func_sel) begin
            clr_fe = !st_q.w_data[ucsf_pkg::CTL_BIT7]; // R5 R6
          end else begin
            st_d.mode[1] = st_q.w_data[ucsf_pkg::CTL_BIT7]; // R5 R8
          end
          st_d.mode[0]  = st_q.w_data[ucsf_pkg::CTL_MODE_LO]; // R8
          st_d.mp_filt  = st_q.w_data[ucsf_pkg::CTL_MP_FILT];
          st_d.rx_en    = st_q.w_data[ucsf_pkg::CTL_RX_EN]; // R2
          st_d.ninth_tx = st_q.w_data[ucsf_pkg::CTL_NINTH_TX]; // R1
          st_d.ninth_rx = st_q.w_data[ucsf_pkg::CTL_NINTH_RX];
          clr_ti        = !st_q.w_data[ucsf_pkg::CTL_TX_DONE]; // R20
          clr_ri        = !st_q.w_data[ucsf_pkg::CTL_RX_DONE]; // R20
        end else if (wsel == ucsf_pkg::SEL_STAT) begin
          st_d.irq_en = st_q.w_data[ucsf_pkg::STS_IRQ_EN];
          clr_oe      = !st_q.w_data[ucsf_pkg::STS_OVERRUN]; // R20
          clr_br      = !st_q.w_data[ucsf_pkg::STS_BREAK]; // R20
          clr_fe      = !st_q.w_data[ucsf_pkg::STS_FRAME]; // R20
          st_d.dbisel = st_q.w_data[ucsf_pkg::STS_DBISEL];
          st_d.split  = st_q.w_data[ucsf_pkg::STS_SPLIT]; // R17
          st_d.intlo  = st_q.w_data[ucsf_pkg::STS_INTLO];
          st_d.dbmod  = st_q.w_data[ucsf_pkg::STS_DBMOD];
        end else if (wsel == ucsf_pkg::SEL_PWR) begin
          st_d.func_sel = st_q.w_data[ucsf_pkg::PWR_FUNC_SEL]; // R18
          st_d.rate_dbl = st_q.w_data[ucsf_pkg::PWR_RATE_DBL];
        end else if (wsel == ucsf_pkg::SEL_AUX) begin
          st_d.brk_rst_en = st_q.w_data[ucsf_pkg::AUX_BRK_RST];
        end
      end
    end

    // A same-cycle hardware set beats a clearing write
    st_d.rx_done   = (st_q.rx_done && !clr_ri) || set_ri; // R20 R3
    st_d.tx_done   = (st_q.tx_done && !clr_ti) || tx_done_stb; // R20
    st_d.frame_err = (st_q.frame_err && !clr_fe) || set_fe; // R20 R6 R16
    st_d.overrun   = (st_q.overrun && !clr_oe) || set_oe; // R20 R14
    st_d.brk       = (st_q.brk && !clr_br) || brk_pulse; // R20 R15
    if (set_ri) begin
      // Ninth data bit in 9-bit modes, stop bit in the 8-bit mode
      st_d.ninth_rx = st_q.mode[1] ? rx_ninth_in : rx_stop_ok;
    end

    // Read channel: one read outstanding, answered on the next edge
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = ucsf_pkg::RESP_OKAY;
      if (rsel == ucsf_pkg::SEL_CTRL) begin
        st_d.rdata = ctrl_view;
      end else if (rsel == ucsf_pkg::SEL_STAT) begin
        st_d.rdata = stat_view;
      end else if (rsel == ucsf_pkg::SEL_PWR) begin
        st_d.rdata = {st_q.rate_dbl, st_q.func_sel, 6'h00};
      end else if (rsel == ucsf_pkg::SEL_AUX) begin
        st_d.rdata = {7'h00, st_q.brk_rst_en};
      end else begin
        st_d.rdata = 8'h00;
        st_d.rresp = ucsf_pkg::RESP_SLVERR;
      end
    end

    // Interrupt requests, registered so they are glitch free
    status_req = st_q.irq_en && (st_q.frame_err || st_q.brk || st_q.overrun); // R10 R11
    if (st_q.split) begin
      st_d.irq_rx = st_q.rx_done || status_req; // R17 R12
      st_d.irq_tx = st_q.tx_done; // R17
    end else begin
      st_d.irq_rx = st_q.rx_done || st_q.tx_done || status_req; // R17 R12
      st_d.irq_tx = 1'b0;
    end
    st_d.brk_rst = brk_pulse && st_q.brk_rst_en; // R13

    st_d.fixed = fixed_d; // R8 R9
    st_d.div   = div_d; // R8 R9
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q            <= '0;
      st_q.mode       <= ucsf_pkg::MODE_SHIFT; // R9
      st_q.mp_filt    <= ucsf_pkg::CTRL_RST[ucsf_pkg::CTL_MP_FILT];
      st_q.rx_en      <= ucsf_pkg::CTRL_RST[ucsf_pkg::CTL_RX_EN];
      st_q.ninth_tx   <= ucsf_pkg::CTRL_RST[ucsf_pkg::CTL_NINTH_TX];
      st_q.irq_en     <= ucsf_pkg::STAT_RST[ucsf_pkg::STS_IRQ_EN];
      st_q.split      <= ucsf_pkg::STAT_RST[ucsf_pkg::STS_SPLIT]; // R17
      st_q.func_sel   <= ucsf_pkg::PWR_RST[ucsf_pkg::PWR_FUNC_SEL];
      st_q.rate_dbl   <= ucsf_pkg::PWR_RST[ucsf_pkg::PWR_RATE_DBL];
      st_q.brk_rst_en <= ucsf_pkg::AUX_RST[ucsf_pkg::AUX_BRK_RST];
      st_q.fixed      <= 1'b1;
      st_q.div        <= ucsf_pkg::DIV_SHIFT; // R9
    end else begin
      st_q <= st_d;
    end
  end

  // Readies stay low while a response waits: one write in flight
  assign s_axi_awready   = !st_q.aw_have && !st_q.bvalid;
  assign s_axi_wready    = !st_q.w_have && !st_q.bvalid;
  assign s_axi_bvalid    = st_q.bvalid;
  assign s_axi_bresp     = st_q.bresp;
  assign s_axi_arready   = !st_q.rvalid;
  assign s_axi_rvalid    = st_q.rvalid;
  assign s_axi_rresp     = st_q.rresp;
  assign s_axi_rdata     = {24'h00_0000, st_q.rdata};
  assign uart_mode       = st_q.mode;
  assign nine_bit_mode   = st_q.mode[1];
  assign fixed_rate      = st_q.fixed;
  assign rate_div        = st_q.div;
  assign ninth_tx_bit    = st_q.ninth_tx; // R1
  assign rx_enable       = st_q.rx_en && !idle_hold; // R2 R19
  assign irq_rx_req      = st_q.irq_rx;
  assign irq_tx_req      = st_q.irq_tx;
  assign break_reset_req = st_q.brk_rst;

endmodule : ucsf_top

//--- dv/test_uart_control_status_flags.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("BAD %s exp %h got %h", nm, (e), (g)); end end
module test_uart_control_status_flags;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, uart_mode, resp;
  logic [31:0] s_axi_rdata;
  logic        rx_bit_stb, rx_bit_val, rx_bit8_stb, rx_frame_stb, rx_ninth_in, rx_stop_ok;
  logic        tx_done_stb, nine_bit_mode, fixed_rate, ninth_tx_bit, rx_enable;
  logic        irq_rx_req, irq_tx_req, break_reset_req;
  logic [5:0]  rate_div;
  logic [7:0]  rd_val;
  int          fails = 0;
  int          check_count = 0;
  logic [5:0]  exp_div [4] = '{6'h10, 6'h00, 6'h20, 6'h00};

  always #5 sys_clk = ~sys_clk;

  ucsf_top i_ucsf_top (.*);
  ucsf_serial_node i_ucsf_serial_node (.*);

  // Sampled 1 ns after an edge, acted on at the next
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    int   n = 0;
    logic aw_hs, w_hs, b_hs = 1'b0;
    @(posedge sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_hs && n < 100) begin
      #1;
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      b_hs  = s_axi_bvalid && s_axi_bready;
      resp  = s_axi_bresp;
      n++;
      @(posedge sys_clk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b_hs) fails++;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    int   n = 0;
    logic ar_hs, r_hs = 1'b0;
    @(posedge sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_hs && n < 100) begin
      #1;
      ar_hs  = s_axi_arvalid && s_axi_arready;
      r_hs   = s_axi_rvalid && s_axi_rready;
      rd_val = s_axi_rdata[7:0];
      resp   = s_axi_rresp;
      n++;
      @(posedge sys_clk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!r_hs) fails++;
    #1;
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    `CHK("mode", 2'b00, uart_mode)
    `CHK("div", 6'h10, rate_div)
    rd(12'h004);
    `CHK("unmapped", ucsf_pkg::RESP_SLVERR, resp)
    wr(12'h004, 8'h00);
    `CHK("unmapped wr", ucsf_pkg::RESP_SLVERR, resp)
    $display("reset test done");
    for (int m = 0; m < 4; m++) begin
      wr(ucsf_pkg::ADDR_CTRL, {m[1:0], 6'h18});
      `CHK("mode", m[1:0], uart_mode)
      `CHK("div", exp_div[m], rate_div)
      `CHK("tx9", 1'b1, ninth_tx_bit)
    end
    wr(ucsf_pkg::ADDR_CTRL, 8'h90);
    `CHK("tx9", 1'b0, ninth_tx_bit)
    wr(ucsf_pkg::ADDR_PWR, 8'h80);
    `CHK("div", 6'h10, rate_div)
    $display("mode test done");
    wr(ucsf_pkg::ADDR_CTRL, 8'hf0);
    i_ucsf_serial_node.send_frame(1'b0, 1'b1);
    rd(ucsf_pkg::ADDR_CTRL);
    `CHK("filtered", 8'hf0, rd_val)
    i_ucsf_serial_node.send_frame(1'b1, 1'b1);
    rd(ucsf_pkg::ADDR_CTRL);
    `CHK("accepted", 8'hf5, rd_val)
    `CHK("rx irq", 1'b1, irq_rx_req)
    i_ucsf_serial_node.send_frame(1'b1, 1'b1);
    rd(ucsf_pkg::ADDR_STAT);
    `CHK("overrun", 8'h02, rd_val)
    $display("filter test done");
    wr(ucsf_pkg::ADDR_STAT, 8'h00);
    wr(ucsf_pkg::ADDR_CTRL, 8'h50);
    i_ucsf_serial_node.send_frame(1'b0, 1'b0);
    wr(ucsf_pkg::ADDR_CTRL, 8'h50);
    i_ucsf_serial_node.send_frame(1'b1, 1'b1);
    wr(ucsf_pkg::ADDR_CTRL, 8'h50);
    rd(ucsf_pkg::ADDR_STAT);
    `CHK("framing", 8'h08, rd_val)
    `CHK("masked irq", 1'b0, irq_rx_req)
    wr(ucsf_pkg::ADDR_STAT, 8'h09);
    `CHK("status irq", 1'b1, irq_rx_req)
    wr(ucsf_pkg::ADDR_PWR, 8'h40);
    rd(ucsf_pkg::ADDR_CTRL);
    `CHK("bit7 framing", 8'hd0, rd_val)
    `CHK("mode kept", 2'b01, uart_mode)
    wr(ucsf_pkg::ADDR_CTRL, 8'h50);
    rd(ucsf_pkg::ADDR_STAT);
    `CHK("cleared", 8'h01, rd_val)
    wr(ucsf_pkg::ADDR_PWR, 8'h00);
    $display("framing test done");
    wr(ucsf_pkg::ADDR_AUX, 8'h01);
    i_ucsf_serial_node.send_bits(11, 1'b0);
    for (int n = 0; n < 5 && break_reset_req !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK("break reset", 1'b1, break_reset_req)
    `CHK("idle", 1'b0, rx_enable)
    rd(ucsf_pkg::ADDR_STAT);
    `CHK("break", 8'h0d, rd_val)
    i_ucsf_serial_node.send_bits(1, 1'b1);
    `CHK("resume", 1'b1, rx_enable)
    $display("break test done");
    wr(ucsf_pkg::ADDR_STAT, 8'h20);
    i_ucsf_serial_node.send_tx_done();
    @(posedge sys_clk);
    #1;
    `CHK("split tx", 1'b1, irq_tx_req)
    wr(ucsf_pkg::ADDR_STAT, 8'h00);
    `CHK("combined tx", 1'b0, irq_tx_req)
    `CHK("combined rx", 1'b1, irq_rx_req)
    $display("interrupt test done");
    end_of_test();
  end
endmodule : test_uart_control_status_flags

//--- dv/ucsf_asserts.sv
`timescale 1ns/1ps
module ucsf_asserts (
  input logic        sys_clk, // Clock
  input logic        nrst, // Reset
  input logic        s_axi_awvalid, // AW valid
  input logic        s_axi_awready, // AW ready
  input logic        s_axi_wvalid, // W valid
  input logic        s_axi_wready, // W ready
  input logic        s_axi_bvalid, // B valid
  input logic        s_axi_arvalid, // AR valid
  input logic        s_axi_arready, // AR ready
  input logic        s_axi_rvalid, // R valid
  input logic [31:0] s_axi_rdata, // R data
  input logic        rx_bit_stb, // Bit strobe
  input logic        rx_bit_val, // Bit value
  input logic        rx_frame_stb, // Frame strobe
  input logic        tx_done_stb, // Tx done
  input logic [1:0]  uart_mode, // Mode
  input logic        nine_bit_mode, // Nine bits
  input logic        fixed_rate, // Fixed rate
  input logic [5:0]  rate_div, // Divisor
  input logic        rx_enable, // Rx enable
  input logic        irq_rx_req, // Rx irq
  input logic        irq_tx_req, // Tx irq
  input logic        break_reset_req // Break reset
);
  logic [4:0] low_cnt_q;

  // Saturates so a long break never wraps
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      low_cnt_q <= 5'h00;
    end else if (!rx_enable) begin
      low_cnt_q <= 5'h00;
    end else if (rx_bit_stb) begin
      low_cnt_q <= rx_bit_val ? 5'h00 : low_cnt_q + {4'h0, low_cnt_q != 5'h1f};
    end
  end

  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence wr_taken_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken_s;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken_s |-> ##2 s_axi_bvalid)
    else $error("b late");
  rd_answer_a: assert property (rd_taken_s |=> s_axi_rvalid)
    else $error("r late");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("rdata high");
  rate_shift_a: assert property ((uart_mode == 2'b00) && ($past(uart_mode) == 2'b00) |->
    rate_div == 6'h10 && fixed_rate) else $error("shift rate");
  rate_var_a: assert property (uart_mode[0] && $past(uart_mode[0]) |->
    rate_div == 6'h00 && !fixed_rate) else $error("var rate");
  nine_mode_a: assert property ($stable(uart_mode) |-> nine_bit_mode == uart_mode[1])
    else $error("nine bit");
  rx_irq_a: assert property (rx_frame_stb && rx_enable && !nine_bit_mode |-> ##2 irq_rx_req)
    else $error("rx irq");
  tx_irq_a: assert property (tx_done_stb |-> ##2 (irq_tx_req || irq_rx_req))
    else $error("tx irq");
  brk_reset_a: assert property (break_reset_req |-> $past(low_cnt_q) >= 5'h0b)
    else $error("early break reset");
  brk_pulse_a: assert property (break_reset_req |=> !break_reset_req)
    else $error("long break reset");
endmodule : ucsf_asserts

bind ucsf_top ucsf_asserts i_ucsf_asserts (.*);

//--- dv/ucsf_serial_node.sv
`timescale 1ns/1ps
module ucsf_serial_node (
  input  wire logic sys_clk,      // Clock
  output logic      rx_bit_stb,   // Bit strobe
  output logic      rx_bit_val,   // Bit value
  output logic      rx_bit8_stb,  // Bit 8 strobe
  output logic      rx_frame_stb, // Frame strobe
  output logic      rx_ninth_in,  // Ninth bit
  output logic      rx_stop_ok,   // Stop bit good
  output logic      tx_done_stb   // Tx done
);
  initial begin
    {rx_bit_stb, rx_bit_val, rx_bit8_stb, rx_frame_stb} = 4'h0;
    {rx_ninth_in, rx_stop_ok, tx_done_stb} = 3'h0;
  end

  // Released lines show the inverse level
  task automatic send_bits(input int n, input logic v);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      rx_bit_stb <= 1'b1;
      rx_bit_val <= v;
    end
    @(posedge sys_clk);
    rx_bit_stb <= 1'b0;
    rx_bit_val <= ~v;
    #1;
  endtask : send_bits

  task automatic send_frame(input logic ninth, input logic stop);
    @(posedge sys_clk);
    rx_bit8_stb <= 1'b1;
    @(posedge sys_clk);
    rx_bit8_stb  <= 1'b0;
    rx_frame_stb <= 1'b1;
    rx_ninth_in  <= ninth;
    rx_stop_ok   <= stop;
    @(posedge sys_clk);
    rx_frame_stb <= 1'b0;
    rx_ninth_in  <= ~ninth;
    rx_stop_ok   <= ~stop;
    #1;
  endtask : send_frame

  task automatic send_tx_done();
    @(posedge sys_clk);
    tx_done_stb <= 1'b1;
    @(posedge sys_clk);
    tx_done_stb <= 1'b0;
    #1;
  endtask : send_tx_done
endmodule : ucsf_serial_node
